// file: rtl/ocmfc_top.sv
// on-chip memory and flash sequencer: SRAM with bit alias, flash with
// erase/program sequencing, unit protection and microsecond timing
// assumes the bus and command requesters sit on sys_clk and hold no
// request while the matching busy output is high
`include "ocmfc_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module ocmfc_top #(
  parameter logic [15:0] ERASE_US = `OCMFC_ERASE_TIME_US
)
(
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire ocmfc_pkg::ocmfc_bus_req_t  busReq,
  output var  ocmfc_pkg::ocmfc_bus_resp_t busResp,
  input  wire ocmfc_pkg::ocmfc_cmd_t      cmdReq,
  output var  ocmfc_pkg::ocmfc_cmd_resp_t cmdResp,
  input  wire logic                       reloadWrite,
  input  wire logic [7:0]                 reloadValue,
  output var  logic [7:0]                 microsecond_reload_count,
  input  wire logic [`OCMFC_UNITS-1:0]    program_enable_mask,
  input  wire logic [`OCMFC_UNITS-1:0]    read_enable_mask
);
  import ocmfc_pkg::*;

  // ===========================================================================
  // declarations
  ocmfc_state_t               s_reg;
  ocmfc_state_t               s_next;
  logic [31:0]                sramOff;
  logic [31:0]                aliasOff;
  logic [31:0]                flashOff;
  logic                       inSram;
  logic                       inAlias;
  logic                       inFlash;
  logic [6:0]                 busUnit;
  logic [6:0]                 cmdUnit;
  logic                       sramWe;
  logic [`OCMFC_SRAM_AW-1:0]  sramAddr;
  logic [31:0]                sramWdata;
  logic [31:0]                sramRdata;
  logic                       flashWe;
  logic [`OCMFC_FLASH_AW-1:0] flashAddr;
  logic [31:0]                flashWdata;
  logic [31:0]                flashRdata;
  logic [31:0]                readWord;
  logic [31:0]                rmwWord;
  logic [15:0]                timerUs;
  logic                       timerDone;

  // ===========================================================================
  // address decode
  // offsets into each region; an unsigned compare catches both ends
  assign sramOff  = busReq.addr - `OCMFC_SRAM_BASE;
  assign aliasOff = busReq.addr - `OCMFC_ALIAS_BASE;
  assign flashOff = busReq.addr - `OCMFC_FLASH_BASE;
  assign inSram   = sramOff < `OCMFC_SRAM_BYTES;
  assign inAlias  = aliasOff < `OCMFC_ALIAS_BYTES;
  assign inFlash  = flashOff < `OCMFC_FLASH_BYTES;

  // protection unit is the 2 KB slice of the flash byte address
  assign busUnit = flashOff[17:11];
  assign cmdUnit = cmdReq.addr[17:11];

  // ===========================================================================
  // arrays
  ocmfc_mem #(
    .AW (`OCMFC_SRAM_AW),
    .DW (32)
  ) u_sram (
    .sys_clk (sys_clk),
    .we      (sramWe),
    .addr    (sramAddr),
    .wdata   (sramWdata),
    .rdata   (sramRdata)
  );

  ocmfc_mem #(
    .AW (`OCMFC_FLASH_AW),
    .DW (32)
  ) u_flash (
    .sys_clk (sys_clk),
    .we      (flashWe),
    .addr    (flashAddr),
    .wdata   (flashWdata),
    .rdata   (flashRdata)
  );

  // ===========================================================================
  // flash operation timer
  // erase and program pulse lengths are counted in microseconds
  assign timerUs = s_reg.isErase ? ERASE_US : `OCMFC_PROG_TIME_US;

  ocmfc_usec_timer u_timer (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .start       (s_reg.timerStart),
    .durationUs  (timerUs),
    .reloadCount (s_reg.usecReload),
    .done        (timerDone)
  );

  // ===========================================================================
  // sequencer
  // bus requests win over commands; one access in flight at a time
  always_comb
  begin
    s_next                 = s_reg;
    s_next.busResp.done    = 1'b0;
    s_next.busResp.fault   = 1'b0;
    s_next.cmdResp.done    = 1'b0;
    s_next.cmdResp.refused = 1'b0;
    s_next.timerStart      = 1'b0;
    sramWe                 = 1'b0;
    sramAddr               = s_reg.sramAddr;
    sramWdata              = s_reg.wdata;
    flashWe                = 1'b0;
    flashAddr              = s_reg.flashAddr;
    flashWdata             = s_reg.wdata;
    readWord               = s_reg.isFlash ? flashRdata : sramRdata;
    rmwWord                = sramRdata;

    // reload count may be rewritten at any time
    if (reloadWrite)
    begin
      s_next.usecReload = reloadValue;
    end

    case (s_reg.fsm)
      S_IDLE:
      begin
        if (busReq.valid)
        begin
          s_next.isAlias = 1'b0;
          s_next.isFlash = 1'b0;
          s_next.wdata   = busReq.wdata;
          if (inSram)
          begin
            // plain SRAM word
            sramAddr        = sramOff[15:2];
            s_next.sramAddr = sramOff[15:2];
            if (busReq.write)
            begin
              sramWe              = 1'b1;
              sramWdata           = busReq.wdata;
              s_next.busResp.done = 1'b1;
            end
            else
            begin
              s_next.fsm = S_READ;
            end
          end
          else if (inAlias)
          begin
            // word holding the target byte, bit = byte lane * 8 + bit
            sramAddr        = aliasOff[20:7];
            s_next.sramAddr = aliasOff[20:7];
            s_next.bitSel   = {aliasOff[6:5], aliasOff[4:2]};
            s_next.isAlias  = 1'b1;
            s_next.fsm      = busReq.write ? S_RMW : S_READ;
          end
          else if (inFlash)
          begin
            if (busReq.write)
            begin
              // flash changes only through the command port
              s_next.busResp.done  = 1'b1;
              s_next.busResp.fault = 1'b1;
            end
            else if ((!busReq.fetch || busReq.debug) && !read_enable_mask[busUnit])
            begin
              // data and debugger reads of a read-disabled unit; a debugger
              // access never counts as an instruction fetch
              s_next.busResp.done  = 1'b1;
              s_next.busResp.fault = 1'b1;
            end
            else
            begin
              flashAddr        = flashOff[17:2];
              s_next.flashAddr = flashOff[17:2];
              s_next.isFlash   = 1'b1;
              s_next.fsm       = S_READ;
            end
          end
          else
          begin
            // unmapped address
            s_next.busResp.done  = 1'b1;
            s_next.busResp.fault = 1'b1;
          end
        end
        else if (cmdReq.valid)
        begin
          if (!program_enable_mask[cmdUnit])
          begin
            // read-only and execute-only units stay untouched
            s_next.cmdResp.refused = 1'b1;
          end
          else if (cmdReq.erase)
          begin
            s_next.flashAddr  = {cmdReq.addr[17:10], 8'h00};
            s_next.isErase    = 1'b1;
            s_next.timerStart = 1'b1;
            s_next.fsm        = S_ER_WAIT;
          end
          else
          begin
            flashAddr        = cmdReq.addr[17:2];
            s_next.flashAddr = cmdReq.addr[17:2];
            s_next.wdata     = cmdReq.data;
            s_next.isErase   = 1'b0;
            s_next.fsm       = S_PG_RD;
          end
        end
      end

      S_READ:
      begin
        // alias reads return the bit alone in bit zero
        if (s_reg.isAlias)
        begin
          s_next.busResp.rdata = {31'h0000_0000, readWord[s_reg.bitSel]};
        end
        else
        begin
          s_next.busResp.rdata = readWord;
        end
        s_next.busResp.done = 1'b1;
        s_next.fsm          = S_IDLE;
      end

      S_RMW:
      begin
        // internal read-modify-write, bus stays stalled throughout
        rmwWord[s_reg.bitSel] = s_reg.wdata[0];
        sramWe                = 1'b1;
        sramWdata             = rmwWord;
        s_next.busResp.done   = 1'b1;
        s_next.fsm            = S_IDLE;
      end

      S_PG_RD:
      begin
        // merge with the stored word so no zero becomes a one
        s_next.wdata      = s_reg.wdata & flashRdata;
        s_next.timerStart = 1'b1;
        s_next.fsm        = S_PG_WAIT;
      end

      S_PG_WAIT:
      begin
        if (timerDone)
        begin
          flashWe             = 1'b1;
          s_next.cmdResp.done = 1'b1;
          s_next.fsm          = S_IDLE;
        end
      end

      S_ER_WAIT:
      begin
        if (timerDone)
        begin
          s_next.fsm = S_ER_FILL;
        end
      end

      S_ER_FILL:
      begin
        // one word of ones per cycle through the 1 KB block
        flashWe          = 1'b1;
        flashWdata       = `OCMFC_ERASED_WORD;
        s_next.flashAddr = s_reg.flashAddr + 16'h0001;
        if (s_reg.flashAddr[7:0] == `OCMFC_BLOCK_LAST)
        begin
          s_next.cmdResp.done = 1'b1;
          s_next.fsm          = S_IDLE;
        end
      end

      default:
      begin
        s_next.fsm = S_IDLE;
      end
    endcase

    s_next.busResp.busy = (s_next.fsm != S_IDLE);
    s_next.cmdResp.busy = (s_next.fsm != S_IDLE);
  end

  // state register with synchronous reset
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_reg            <= '0;
      s_reg.fsm        <= S_IDLE;
      s_reg.usecReload <= `OCMFC_USEC_RELOAD_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ===========================================================================
  // outputs, all straight from the state register
  assign busResp                  = s_reg.busResp;
  assign cmdResp                  = s_reg.cmdResp;
  assign microsecond_reload_count = s_reg.usecReload;

endmodule : ocmfc_top

`default_nettype wire

// file: shared/ocmfc_defs.svh
// constants of the on-chip memory and flash sequencer: map, sizes, timing
// assumes inclusion by bare name from the package and the design files
`ifndef OCMFC_DEFS_SVH
`define OCMFC_DEFS_SVH

// ===========================================================================
// memory map
`define OCMFC_SRAM_BASE        32'h2000_0000
`define OCMFC_SRAM_BYTES       32'h0001_0000
`define OCMFC_ALIAS_BASE       32'h2200_0000
`define OCMFC_ALIAS_BYTES      32'h0020_0000
`define OCMFC_FLASH_BASE       32'h0000_0000
`define OCMFC_FLASH_BYTES      32'h0004_0000

// ===========================================================================
// array geometry
`define OCMFC_SRAM_AW          14
`define OCMFC_FLASH_AW         16
`define OCMFC_UNITS            128
`define OCMFC_ERASED_WORD      32'hFFFF_FFFF
`define OCMFC_BLOCK_LAST       8'hFF

// ===========================================================================
// timing
`define OCMFC_USEC_RELOAD_RST  8'h7C
`define OCMFC_PROG_TIME_US     16'h0014
`define OCMFC_ERASE_TIME_US    16'h2EE0

`endif

// file: shared/ocmfc_pkg.sv
// types of the on-chip memory and flash sequencer
// assumes ocmfc_defs.svh on the include path
`include "ocmfc_defs.svh"

package ocmfc_pkg;

  // ===========================================================================
  // sequencer states, one-hot
  typedef enum logic [6:0]
  {
    S_IDLE    = 7'h01,
    S_READ    = 7'h02,
    S_RMW     = 7'h04,
    S_PG_RD   = 7'h08,
    S_PG_WAIT = 7'h10,
    S_ER_WAIT = 7'h20,
    S_ER_FILL = 7'h40
  } ocmfc_fsm_t;

  // ===========================================================================
  // system bus request and answer
  typedef struct packed
  {
    logic        valid;
    logic        write;
    logic        fetch;
    logic        debug;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ocmfc_bus_req_t;

  typedef struct packed
  {
    logic        busy;
    logic        done;
    logic        fault;
    logic [31:0] rdata;
  } ocmfc_bus_resp_t;

  // ===========================================================================
  // flash erase and program command and answer
  typedef struct packed
  {
    logic        valid;
    logic        erase;
    logic [17:0] addr;
    logic [31:0] data;
  } ocmfc_cmd_t;

  typedef struct packed
  {
    logic busy;
    logic done;
    logic refused;
  } ocmfc_cmd_resp_t;

  // ===========================================================================
  // whole state of the sequencer
  typedef struct packed
  {
    ocmfc_fsm_t      fsm;
    ocmfc_bus_resp_t busResp;
    ocmfc_cmd_resp_t cmdResp;
    logic [7:0]      usecReload;
    logic            isAlias;
    logic            isFlash;
    logic            isErase;
    logic            timerStart;
    logic [4:0]      bitSel;
    logic [13:0]     sramAddr;
    logic [15:0]     flashAddr;
    logic [31:0]     wdata;
  } ocmfc_state_t;

  // state of the microsecond timer
  typedef struct packed
  {
    logic        running;
    logic        done;
    logic [7:0]  cycleCnt;
    logic [15:0] usLeft;
  } ocmfc_timer_t;

endpackage : ocmfc_pkg

// file: rtl/ocmfc_mem.sv
// single-port word memory with registered read data
// assumes one access per cycle; array contents are not reset
`timescale 1ns/1ns
`default_nettype none

module ocmfc_mem #(
  parameter int AW = 14,
  parameter int DW = 32
)
(
  input  wire logic          sys_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output var  logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // write port and read register
  always_ff @(posedge sys_clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule : ocmfc_mem

`default_nettype wire

// file: rtl/ocmfc_usec_timer.sv
// microsecond timer: one tick every reload+1 clocks, done after a count of ticks
// assumes start is a one-cycle pulse from the sequencer on the same clock
`timescale 1ns/1ns
`default_nettype none

module ocmfc_usec_timer
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [15:0] durationUs,
  input  wire logic [7:0]  reloadCount,
  output var  logic        done
);
  import ocmfc_pkg::*;

  ocmfc_timer_t t_reg;
  ocmfc_timer_t t_next;

  // next state of the tick and microsecond counters
  always_comb
  begin
    t_next      = t_reg;
    t_next.done = 1'b0;
    if (start)
    begin
      t_next.running  = 1'b1;
      t_next.cycleCnt = reloadCount;
      t_next.usLeft   = (durationUs == 16'h0000) ? 16'h0001 : durationUs;
    end
    else if (t_reg.running)
    begin
      if (t_reg.cycleCnt == 8'h00)
      begin
        t_next.cycleCnt = reloadCount;
        if (t_reg.usLeft == 16'h0001)
        begin
          t_next.running = 1'b0;
          t_next.done    = 1'b1;
        end
        else
        begin
          t_next.usLeft = t_reg.usLeft - 16'h0001;
        end
      end
      else
      begin
        t_next.cycleCnt = t_reg.cycleCnt - 8'h01;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      t_reg <= '0;
    end
    else
    begin
      t_reg <= t_next;
    end
  end

  assign done = t_reg.done;

endmodule : ocmfc_usec_timer

`default_nettype wire

// file: tb/ocmfc_top_properties.sv
// checker on the sequencer ports: bus answer timing, protection, reload count
// assumes ocmfc_pkg compiled first; bound onto every ocmfc_top
`include "ocmfc_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module ocmfc_top_properties #(
  parameter logic [15:0] ERASE_US = `OCMFC_ERASE_TIME_US
)
(
  input wire logic                       sys_clk,
  input wire logic                       rst,
  input wire ocmfc_pkg::ocmfc_bus_req_t  busReq,
  input wire ocmfc_pkg::ocmfc_bus_resp_t busResp,
  input wire ocmfc_pkg::ocmfc_cmd_t      cmdReq,
  input wire ocmfc_pkg::ocmfc_cmd_resp_t cmdResp,
  input wire logic                       reloadWrite,
  input wire logic [7:0]                 reloadValue,
  input wire logic [7:0]                 microsecond_reload_count,
  input wire logic [`OCMFC_UNITS-1:0]    program_enable_mask,
  input wire logic [`OCMFC_UNITS-1:0]    read_enable_mask
);
  import ocmfc_pkg::*;

  // =====================
  // request takes and address decode
  logic busTake;
  logic cmdTake;
  logic inSram;
  logic inFlash;
  logic inAlias;
  logic rdTake;
  assign busTake = busReq.valid && !busResp.busy;
  assign cmdTake = cmdReq.valid && !busResp.busy && !busReq.valid;
  assign inSram  = busReq.addr[31:16] == 16'h2000;
  assign inFlash = busReq.addr[31:18] == 14'h0000;
  assign inAlias = busReq.addr[31:21] == 11'h110;
  assign rdTake  = busTake && !busReq.write;

  // =====================
  // assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  AST_SRAM_READ: assert property (rdTake && inSram
    |=> busResp.busy && !busResp.done ##1 busResp.done && !busResp.fault)
    else $error("sram read answer out of time");
  AST_UNMAPPED: assert property (busTake && !inSram && !inFlash && !inAlias
    |=> busResp.done && busResp.fault)
    else $error("unmapped access not faulted");
  AST_ALIAS_WRITE: assert property (busTake && busReq.write && inAlias
    |=> !busResp.done ##1 busResp.done && !busResp.fault)
    else $error("alias write answer out of time");
  AST_FLASH_WRITE: assert property (busTake && busReq.write && inFlash
    |=> busResp.done && busResp.fault)
    else $error("bus write to flash not faulted");
  AST_READ_PROT: assert property (rdTake && inFlash && !busReq.fetch
    && !read_enable_mask[busReq.addr[17:11]] |=> busResp.done && busResp.fault)
    else $error("protected data read not faulted");
  AST_FETCH: assert property (rdTake && inFlash && busReq.fetch && !busReq.debug
    |=> !busResp.done ##1 busResp.done && !busResp.fault)
    else $error("fetch read not answered");
  AST_REFUSE: assert property (cmdTake && !program_enable_mask[cmdReq.addr[17:11]]
    |=> cmdResp.refused && !cmdResp.done)
    else $error("protected command not refused");
  AST_PROG_TIME: assert property (cmdTake && !cmdReq.erase
    && program_enable_mask[cmdReq.addr[17:11]] && microsecond_reload_count < 8'h20
    |=> (cmdResp.busy && !cmdResp.done) [*8] ##[1:1000] cmdResp.done)
    else $error("program timing wrong");
  AST_RESET_RELOAD: assert property ($fell(rst)
    |-> microsecond_reload_count == `OCMFC_USEC_RELOAD_RST)
    else $error("reload count not at default after reset");
  AST_RELOAD_LOAD: assert property (reloadWrite
    |=> microsecond_reload_count == $past(reloadValue))
    else $error("reload count not loaded");

  // main scenarios reached
  COV_REFUSED: cover property (cmdResp.refused);
  COV_CMD_DONE: cover property (cmdResp.done);
  COV_FAULT: cover property (busResp.fault);

endmodule : ocmfc_top_properties

bind ocmfc_top ocmfc_top_properties #(.ERASE_US(ERASE_US)) ocmfc_top_properties_i
(
  .sys_clk                  (sys_clk),
  .rst                      (rst),
  .busReq                   (busReq),
  .busResp                  (busResp),
  .cmdReq                   (cmdReq),
  .cmdResp                  (cmdResp),
  .reloadWrite              (reloadWrite),
  .reloadValue              (reloadValue),
  .microsecond_reload_count (microsecond_reload_count),
  .program_enable_mask      (program_enable_mask),
  .read_enable_mask         (read_enable_mask)
);

`default_nettype wire

// file: tb/ocmfc_bus_master.sv
// processor and debugger side: bus accesses, flash commands, reload writes
// assumes tasks are called one at a time from the bench
`timescale 1ns/1ns
`default_nettype none

module ocmfc_bus_master
(
  input  wire logic                       sys_clk,
  input  wire ocmfc_pkg::ocmfc_bus_resp_t busResp,
  input  wire ocmfc_pkg::ocmfc_cmd_resp_t cmdResp,
  output var  ocmfc_pkg::ocmfc_bus_req_t  busReq,
  output var  ocmfc_pkg::ocmfc_cmd_t      cmdReq,
  output var  logic                       reloadWrite,
  output var  logic [7:0]                 reloadValue
);
  import ocmfc_pkg::*;

  // idle requests at time zero
  initial
  begin
    busReq = '0;
    cmdReq = '0;
    reloadWrite = 1'b0;
    reloadValue = 8'h00;
  end

  // new clock rate in MHz minus one, written before any flash change
  task automatic setReload(input logic [7:0] v);
    @(posedge sys_clk);
    reloadWrite <= 1'b1;
    reloadValue <= v;
    @(posedge sys_clk);
    reloadWrite <= 1'b0;
    reloadValue <= ~v;
  endtask : setReload

  // one bus access; released lines show inverted values
  task automatic busAccess(input logic wr, fe, dbg, input logic [31:0] a, w,
                           output logic [31:0] rd, output logic flt);
    int n;
    while (busResp.busy === 1'b1) @(posedge sys_clk);
    busReq <= '{valid:1'b1, write:wr, fetch:fe, debug:dbg, addr:a, wdata:w};
    @(posedge sys_clk);
    busReq <= '{valid:1'b0, write:~wr, fetch:~fe, debug:~dbg, addr:~a, wdata:~w};
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (busResp.done !== 1'b1 && n < 50);
    // a lost answer reads as unknown so every compare on it fails
    rd  = (busResp.done === 1'b1) ? busResp.rdata : 'x;
    flt = (busResp.done === 1'b1) ? busResp.fault : 1'bx;
  endtask : busAccess

  // one erase or program command, waits for done or refusal
  task automatic cmdRun(input logic er, input logic [17:0] a, input logic [31:0] d,
                        output logic refd);
    int n;
    while (busResp.busy === 1'b1) @(posedge sys_clk);
    cmdReq <= '{valid:1'b1, erase:er, addr:a, data:d};
    @(posedge sys_clk);
    cmdReq <= '{valid:1'b0, erase:~er, addr:~a, data:~d};
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (cmdResp.done !== 1'b1 && cmdResp.refused !== 1'b1 && n < 5000);
    // a command that never ends reads as unknown so its compare fails
    refd = (cmdResp.done === 1'b1 || cmdResp.refused === 1'b1) ? cmdResp.refused : 1'bx;
  endtask : cmdRun

endmodule : ocmfc_bus_master

`default_nettype wire

// file: tb/tb_onchip_memory_flash_controller.sv
// self-checking bench: memory model in queues and arrays against the sequencer
// assumes ocmfc_pkg, the design and the bus master model are compiled first
`include "ocmfc_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_onchip_memory_flash_controller;
  import ocmfc_pkg::*;

  logic                    sys_clk;
  logic                    rst;
  ocmfc_bus_req_t          busReq;
  ocmfc_bus_resp_t         busResp;
  ocmfc_cmd_t              cmdReq;
  ocmfc_cmd_resp_t         cmdResp;
  logic                    reloadWrite;
  logic [7:0]              reloadValue;
  logic [7:0]              reloadCount;
  logic [`OCMFC_UNITS-1:0] progEn;
  logic [`OCMFC_UNITS-1:0] readEn;
  logic [31:0]             rd, a, w, al;
  logic                    flt, refd, ex;
  logic [31:0]             sram [int];
  logic [31:0]             flash [int];
  logic [31:0]             addrQ [$];
  int                      seed, b, miscompares, check_count;

  ocmfc_top #(.ERASE_US(16'h0002)) ocmfc_top_i
  (
    .sys_clk (sys_clk), .rst (rst), .busReq (busReq), .busResp (busResp),
    .cmdReq (cmdReq), .cmdResp (cmdResp), .reloadWrite (reloadWrite),
    .reloadValue (reloadValue), .microsecond_reload_count (reloadCount),
    .program_enable_mask (progEn), .read_enable_mask (readEn)
  );

  ocmfc_bus_master ocmfc_bus_master_i
  (
    .sys_clk (sys_clk), .busResp (busResp), .cmdResp (cmdResp), .busReq (busReq),
    .cmdReq (cmdReq), .reloadWrite (reloadWrite), .reloadValue (reloadValue)
  );

  // =====================
  // compares and verdict
  task automatic checkWord(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: word %h, model %h", $time, got, exp);
    end
  endtask : checkWord

  task automatic checkFlag(input logic got, exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: flag %b, model %b", $time, got, exp);
    end
  endtask : checkFlag

  task automatic conclude();
    $display("comparisons %0d, miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // shorthands for the partner tasks; kind bit 0 fetch, bit 1 debugger
  task automatic busDo(input logic wr, input logic [1:0] kind, input logic [31:0] ad, wd);
    ocmfc_bus_master_i.busAccess(wr, kind[0], kind[1], ad, wd, rd, flt);
  endtask : busDo

  task automatic cmdDo(input logic er, input logic [17:0] ad, input logic [31:0] d);
    ocmfc_bus_master_i.cmdRun(er, ad, d, refd);
  endtask : cmdDo

  // =====================
  // clock and watchdog
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial
  begin
    #400000;
    miscompares++;
    conclude();
  end

  // =====================
  // scenarios
  initial
  begin
    seed = 62447;
    rst = 1'b1;
    progEn = '1;
    readEn = '1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1 checkWord({24'h0, reloadCount}, {24'h0, `OCMFC_USEC_RELOAD_RST});
    ocmfc_bus_master_i.setReload(8'h01);
    #1 checkWord({24'h0, reloadCount}, 32'h0000_0001);
    // sram at random words and the last word, written then read back
    for (int i = 0; i < 6; i++)
    begin
      a = (i == 5) ? 32'h2000_FFFC : (32'h2000_0000 | ($random(seed) & 32'h0000_FFFC));
      w = $random(seed);
      addrQ.push_back(a);
      sram[a[15:2]] = w;
      busDo(1'b1, 2'b00, a, w);
      checkFlag(flt, 1'b0);
    end
    foreach (addrQ[i])
    begin
      busDo(1'b0, 2'b00, addrQ[i], 32'h0);
      checkWord(rd, sram[addrQ[i][15:2]]);
    end
    // single bits through the alias window
    for (int i = 0; i < 4; i++)
    begin
      a = addrQ[i];
      b = $unsigned($random(seed)) % 32;
      w = $random(seed);
      al = 32'h2200_0000 + (a[15:0] + b / 8) * 32 + (b % 8) * 4;
      sram[a[15:2]][b] = w[0];
      busDo(1'b1, 2'b00, al, w);
      checkFlag(flt, 1'b0);
      busDo(1'b0, 2'b00, al, 32'h0);
      checkWord(rd, {31'h0, sram[a[15:2]][b]});
      busDo(1'b0, 2'b00, a, 32'h0);
      checkWord(rd, sram[a[15:2]]);
    end
    // unmapped read and bus write to flash fault
    busDo(1'b0, 2'b00, 32'h2001_0000, 32'h0);
    checkFlag(flt, 1'b1);
    busDo(1'b1, 2'b00, 32'h0000_0014, w);
    checkFlag(flt, 1'b1);
    // erase blocks 0..4 with the second unit locked
    progEn[1] <= 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      ex = (k / 2 == 1);
      cmdDo(1'b1, 18'(k << 10), 32'h0);
      checkFlag(refd, ex);
      for (int j = 0; j < 256; j++)
        if (!ex) flash[k * 256 + j] = 32'hFFFF_FFFF;
    end
    foreach (addrQ[i])
    begin
      busDo(1'b0, 2'b00, {22'h0, 10'(i * 51) & 10'h3FC}, 32'h0);
      checkWord(rd, flash[(i * 51) / 4 & 8'hFF]);
    end
    busDo(1'b0, 2'b00, 32'h0000_13FC, 32'h0);
    checkWord(rd, flash[1279]);
    // two programs of one word only clear bits
    for (int i = 0; i < 2; i++)
    begin
      w = $random(seed);
      cmdDo(1'b0, 18'h00014, w);
      checkFlag(refd, 1'b0);
      flash[5] = flash[5] & w;
    end
    busDo(1'b0, 2'b00, 32'h0000_0014, 32'h0);
    checkWord(rd, flash[5]);
    // locked unit refuses a program and keeps its word
    progEn[0] <= 1'b0;
    cmdDo(1'b0, 18'h00014, 32'h0);
    checkFlag(refd, 1'b1);
    // execute-only unit: data and debugger reads fault, fetch reads
    readEn[0] <= 1'b0;
    busDo(1'b0, 2'b00, 32'h0000_0014, 32'h0);
    checkFlag(flt, 1'b1);
    busDo(1'b0, 2'b10, 32'h0000_0014, 32'h0);
    checkFlag(flt, 1'b1);
    busDo(1'b0, 2'b01, 32'h0000_0014, 32'h0);
    checkWord(rd, flash[5]);
    checkFlag(flt, 1'b0);
    conclude();
  end

endmodule : tb_onchip_memory_flash_controller

`default_nettype wire
